/* src/tsi_params.svh */
`ifndef TSI_PARAMS_SVH
`define TSI_PARAMS_SVH

// slave addresses selected by the address-select strap
`define TSI_ADDR_VDD 7'h5a
`define TSI_ADDR_VSS 7'h5b
`define TSI_ADDR_SDA 7'h5c
`define TSI_ADDR_SCL 7'h5d

// strap encodings
`define TSI_ASEL_VDD 2'h0
`define TSI_ASEL_VSS 2'h1
`define TSI_ASEL_SDA 2'h2
`define TSI_ASEL_SCL 2'h3

// byte framing
`define TSI_BITS_PER_BYTE 4'h8
`define TSI_LAST_TX_BIT 4'h7
`define TSI_ACK_BIT_IDX 4'h8

// pointer auto-increment exception: the pointer leaves WRAP_FROM for WRAP_TO
`define TSI_PTR_RESET 8'h00
`define TSI_PTR_WRAP_FROM 8'h7f
`define TSI_PTR_WRAP_TO 8'h00

// master timing: one quarter of an scl period, least time
`define TSI_SYS_PERIOD_NS 20
`define TSI_SCL_QTR_NS 2500
`define TSI_SCL_QTR_CYC ((`TSI_SCL_QTR_NS + `TSI_SYS_PERIOD_NS - 1) / `TSI_SYS_PERIOD_NS)

`endif

/* src/tsi_pkg.sv */
package tsi_pkg;
    typedef logic [1:0] tsi_asel_t;

    typedef enum logic [3:0] {
        D_IDLE,
        D_ADDR,
        D_CMD,
        D_WDAT,
        D_ACK,
        D_TX,
        D_MACK,
        D_IGNORE
    } tsi_dev_st_t;

    typedef enum logic [1:0] {
        H_IDLE,
        H_RUN
    } tsi_host_st_t;

    typedef enum logic [1:0] {
        OP_START,
        OP_STOP,
        OP_WRITE,
        OP_READ
    } tsi_op_t;
endpackage : tsi_pkg

/* src/tsi_link_if.sv */
`timescale 1ns/1ns
interface tsi_link_if;
    logic scl_o;
    logic scl_oe;
    logic scl_i;
    logic sda_h_o;
    logic sda_h_oe;
    logic sda_d_o;
    logic sda_d_oe;
    logic sda_i;

    // open-drain wires with pull-ups: a line is low only while someone pulls it low
    assign scl_i = ~(scl_oe & ~scl_o);
    assign sda_i = ~((sda_h_oe & ~sda_h_o) | (sda_d_oe & ~sda_d_o));

    modport dev (input scl_i, input sda_i, output sda_d_o, output sda_d_oe);
    modport host (output scl_o, output scl_oe, input sda_i, output sda_h_o, output sda_h_oe);
endinterface : tsi_link_if

/* src/tsi_dev_port.sv */
`timescale 1ns/1ns
// Overview of operation
// - device is slave; master starts, clocks everything
// - scl input only; sda open-drain pull-low
// - start, address+direction, pointer byte, data, stop
// - idle bus: both lines released high
// - sda falling while scl high is start
// - sda rising while scl high is stop
// - one bit per clock; sda steady while high
// - strap picks address 0x5a to 0x5d
// - always watch for start plus own address
// - eighth bit: low write, high read
// - acknowledge own address, engaged until next start or stop
// - ninth pulse: receiver pulls sda low
// - device acks writes, master acks reads
// - first write byte loads the pointer only
// - data bytes written at pointer, pointer advances
// - reads come from pointer, pointer advances
// - master reads via pointer write, repeated start, nack
// - multi-master: repeated start between write and read
// - start owns bus until stop; pointer rewritable
`include "tsi_params.svh"
module tsi_dev_port (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic clk_link,
    tsi_link_if.dev link,
    input wire tsi_pkg::tsi_asel_t addr_sel,
    output logic reg_wr_en,
    output logic reg_rd_en,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    output logic link_busy
);
    import tsi_pkg::*;

    function automatic logic [6:0] own_addr(input tsi_asel_t sel);
        case (sel)
            `TSI_ASEL_VDD: own_addr = `TSI_ADDR_VDD;
            `TSI_ASEL_VSS: own_addr = `TSI_ADDR_VSS;
            `TSI_ASEL_SDA: own_addr = `TSI_ADDR_SDA;
            default: own_addr = `TSI_ADDR_SCL;
        endcase
    endfunction : own_addr

    // register map exceptions live here, not in the adder
    function automatic logic [7:0] ptr_step(input logic [7:0] p);
        if (p == `TSI_PTR_WRAP_FROM) begin
            ptr_step = `TSI_PTR_WRAP_TO;
        end else begin
            ptr_step = p + 8'h01;
        end
    endfunction : ptr_step

    // link domain
    logic rst_m_q, rst_l_q;
    logic scl_m_q, scl_s_q, scl_p_q;
    logic sda_m_q, sda_s_q, sda_p_q;
    tsi_asel_t asel_m_q, asel_s_q;
    logic ack_m_q, ack_s_q, ack_p_q;
    tsi_dev_st_t st_q, nxt_q;
    logic [3:0] cnt_q;
    logic [7:0] sh_q, ptr_q, rdat_q;
    logic sda_low_q, mack_q, engaged_q;
    logic req_t_q, req_wr_q;
    logic [7:0] req_addr_q, req_data_q;

    // system domain
    logic req_m_q, req_s_q, req_p_q;
    logic eng_m_q, eng_s_q;
    logic wr_en_q, rd_en_q, ack_t_q;
    logic [7:0] addr_q, wdata_q, rdq_q;

    // pins are asynchronous to clk_link: two flops before any decode
    always_ff @(posedge clk_link) begin
        rst_m_q <= rst;
        rst_l_q <= rst_m_q;
        scl_m_q <= link.scl_i;
        scl_s_q <= scl_m_q;
        scl_p_q <= scl_s_q;
        sda_m_q <= link.sda_i;
        sda_s_q <= sda_m_q;
        sda_p_q <= sda_s_q;
        asel_m_q <= addr_sel;
        asel_s_q <= asel_m_q;
        ack_m_q <= ack_t_q;
        ack_s_q <= ack_m_q;
        ack_p_q <= ack_s_q;
    end

    wire scl_rise = scl_s_q & ~scl_p_q;
    wire scl_fall = ~scl_s_q & scl_p_q;
    wire start_c = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
    wire stop_c = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
    wire byte_done = scl_fall & (cnt_q == `TSI_BITS_PER_BYTE);
    wire addr_hit = (sh_q[7:1] == own_addr(asel_s_q));
    wire [7:0] ptr_nx = ptr_step(ptr_q);
    wire rdat_new = ack_s_q ^ ack_p_q;

    // sda only ever pulled low, never driven high
    assign link.sda_d_o = 1'b0;
    assign link.sda_d_oe = sda_low_q;

    // read data follows the request handshake; one scl period (the ack clock) is ample for it
    always_ff @(posedge clk_link) begin
        if (rst_l_q) begin
            rdat_q <= 8'h00;
        end else if (rdat_new) begin
            rdat_q <= rdq_q;
        end
    end

    always_ff @(posedge clk_link) begin
        if (rst_l_q) begin
            st_q <= D_IDLE;
            nxt_q <= D_IDLE;
            cnt_q <= 4'h0;
            sh_q <= 8'h00;
            ptr_q <= `TSI_PTR_RESET;
            sda_low_q <= 1'b0;
            mack_q <= 1'b0;
            engaged_q <= 1'b0;
            req_t_q <= 1'b0;
            req_wr_q <= 1'b0;
            req_addr_q <= 8'h00;
            req_data_q <= 8'h00;
        end else if (start_c) begin
            // any start, even mid-byte, restarts address reception; pointer kept
            st_q <= D_ADDR;
            cnt_q <= 4'h0;
            sda_low_q <= 1'b0;
            engaged_q <= 1'b0;
        end else if (stop_c) begin
            st_q <= D_IDLE;
            sda_low_q <= 1'b0;
            engaged_q <= 1'b0;
        end else begin
            case (st_q)
                D_ADDR, D_CMD, D_WDAT: begin
                    if (scl_rise && cnt_q != `TSI_BITS_PER_BYTE) begin
                        sh_q <= {sh_q[6:0], sda_s_q};
                        cnt_q <= cnt_q + 4'h1;
                    end
                    if (byte_done) begin
                        sda_low_q <= 1'b1;
                        st_q <= D_ACK;
                        if (st_q == D_ADDR) begin
                            if (addr_hit) begin
                                engaged_q <= 1'b1;
                                nxt_q <= sh_q[0] ? D_TX : D_CMD;
                                if (sh_q[0]) begin
                                    req_t_q <= ~req_t_q;
                                    req_wr_q <= 1'b0;
                                    req_addr_q <= ptr_q;
                                end
                            end else begin
                                sda_low_q <= 1'b0;
                                st_q <= D_IGNORE;
                            end
                        end else if (st_q == D_CMD) begin
                            ptr_q <= sh_q;
                            nxt_q <= D_WDAT;
                        end else begin
                            req_t_q <= ~req_t_q;
                            req_wr_q <= 1'b1;
                            req_addr_q <= ptr_q;
                            req_data_q <= sh_q;
                            ptr_q <= ptr_nx;
                            nxt_q <= D_WDAT;
                        end
                    end
                end
                D_ACK: begin
                    if (scl_fall) begin
                        cnt_q <= 4'h0;
                        st_q <= nxt_q;
                        if (nxt_q == D_TX) begin
                            sh_q <= rdat_q;
                            sda_low_q <= ~rdat_q[7];
                        end else begin
                            sda_low_q <= 1'b0;
                        end
                    end
                end
                D_TX: begin
                    // bits change only after scl falls, so sda is steady while high
                    if (scl_fall) begin
                        if (cnt_q == `TSI_LAST_TX_BIT) begin
                            sda_low_q <= 1'b0;
                            st_q <= D_MACK;
                            ptr_q <= ptr_nx;
                            req_t_q <= ~req_t_q;
                            req_wr_q <= 1'b0;
                            req_addr_q <= ptr_nx;
                        end else begin
                            sh_q <= {sh_q[6:0], 1'b0};
                            sda_low_q <= ~sh_q[6];
                            cnt_q <= cnt_q + 4'h1;
                        end
                    end
                end
                D_MACK: begin
                    if (scl_rise) begin
                        mack_q <= ~sda_s_q;
                    end
                    if (scl_fall) begin
                        cnt_q <= 4'h0;
                        if (mack_q) begin
                            st_q <= D_TX;
                            sh_q <= rdat_q;
                            sda_low_q <= ~rdat_q[7];
                        end else begin
                            st_q <= D_IGNORE;
                        end
                    end
                end
                default: begin
                    sda_low_q <= 1'b0;
                end
            endcase
        end
    end

    // request fields are held stable from the toggle until the next request
    always_ff @(posedge clk_sys) begin
        req_m_q <= req_t_q;
        req_s_q <= req_m_q;
        eng_m_q <= engaged_q;
        eng_s_q <= eng_m_q;
    end

    wire req_new = req_s_q ^ req_p_q;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            req_p_q <= 1'b0;
            wr_en_q <= 1'b0;
            rd_en_q <= 1'b0;
            addr_q <= 8'h00;
            wdata_q <= 8'h00;
            rdq_q <= 8'h00;
            ack_t_q <= 1'b0;
            link_busy <= 1'b0;
        end else begin
            req_p_q <= req_s_q;
            wr_en_q <= req_new & req_wr_q;
            rd_en_q <= req_new & ~req_wr_q;
            link_busy <= eng_s_q;
            if (req_new) begin
                addr_q <= req_addr_q;
                wdata_q <= req_data_q;
            end
            if (rd_en_q) begin
                rdq_q <= reg_rdata;
            end
            if (wr_en_q || rd_en_q) begin
                ack_t_q <= ~ack_t_q;
            end
        end
    end

    assign reg_wr_en = wr_en_q;
    assign reg_rd_en = rd_en_q;
    assign reg_addr = addr_q;
    assign reg_wdata = wdata_q;
endmodule : tsi_dev_port

/* src/tsi_host_master.sv */
`timescale 1ns/1ns
`include "tsi_params.svh"
module tsi_host_master (
    input wire logic clk_sys,
    input wire logic rst,
    tsi_link_if.host link,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire tsi_pkg::tsi_op_t cmd_op,
    input wire logic [7:0] cmd_data,
    input wire logic cmd_last,
    output logic rsp_valid,
    output logic [7:0] rsp_data,
    output logic rsp_nack
);
    import tsi_pkg::*;

    localparam logic [15:0] QTR_CYC = 16'(`TSI_SCL_QTR_CYC);

    tsi_host_st_t st_q;
    tsi_op_t op_q;
    logic [15:0] div_q;
    logic [1:0] ph_q;
    logic [3:0] bit_q;
    logic [8:0] bits_q, rx_q;
    logic scl_low_q, sda_low_q;
    logic sda_m_q, sda_s_q;

    always_ff @(posedge clk_sys) begin
        sda_m_q <= link.sda_i;
        sda_s_q <= sda_m_q;
    end

    wire tick = (div_q == QTR_CYC - 16'h0001);
    wire accept = cmd_valid & cmd_ready;
    wire is_bit = (op_q == OP_WRITE) | (op_q == OP_READ);
    // read: the ninth slot carries the nack level, so a last byte leaves sda released
    wire [8:0] load_bits = (cmd_op == OP_WRITE) ? {cmd_data, 1'b1} : {8'hff, cmd_last};

    assign cmd_ready = (st_q == H_IDLE);
    assign link.scl_o = 1'b0;
    assign link.scl_oe = scl_low_q;
    assign link.sda_h_o = 1'b0;
    assign link.sda_h_oe = sda_low_q;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_q <= H_IDLE;
            op_q <= OP_START;
            div_q <= 16'h0000;
            ph_q <= 2'h0;
            bit_q <= 4'h0;
            bits_q <= 9'h1ff;
            rx_q <= 9'h000;
            scl_low_q <= 1'b0;
            sda_low_q <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_data <= 8'h00;
            rsp_nack <= 1'b0;
        end else begin
            rsp_valid <= 1'b0;
            if (accept) begin
                st_q <= H_RUN;
                op_q <= cmd_op;
                div_q <= 16'h0000;
                ph_q <= 2'h0;
                bit_q <= 4'h0;
                bits_q <= load_bits;
                case (cmd_op)
                    OP_START: sda_low_q <= 1'b0;
                    OP_STOP: sda_low_q <= 1'b1;
                    default: sda_low_q <= ~load_bits[8];
                endcase
            end else if (st_q == H_RUN) begin
                div_q <= tick ? 16'h0000 : div_q + 16'h0001;
                if (tick) begin
                    ph_q <= ph_q + 2'h1;
                    case (ph_q)
                        2'h0: scl_low_q <= 1'b0;
                        2'h1: begin
                            if (op_q == OP_START) begin
                                sda_low_q <= 1'b1;
                            end else if (op_q == OP_STOP) begin
                                sda_low_q <= 1'b0;
                            end else begin
                                rx_q <= {rx_q[7:0], sda_s_q};
                            end
                        end
                        2'h2: begin
                            if (op_q != OP_STOP) begin
                                scl_low_q <= 1'b1;
                            end
                        end
                        default: begin
                            // data moves only in the low phase
                            if (is_bit && bit_q != `TSI_ACK_BIT_IDX) begin
                                bits_q <= {bits_q[7:0], 1'b1};
                                sda_low_q <= ~bits_q[7];
                                bit_q <= bit_q + 4'h1;
                            end else begin
                                st_q <= H_IDLE;
                                rsp_valid <= is_bit;
                                rsp_data <= rx_q[8:1];
                                rsp_nack <= rx_q[0];
                            end
                        end
                    endcase
                end
            end
        end
    end
endmodule : tsi_host_master

/* bench/tsi_link_properties.sv */
`timescale 1ns/1ns
module tsi_link_properties (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic clk_link,
    input wire logic scl_o,
    input wire logic scl_oe,
    input wire logic scl_i,
    input wire logic sda_h_o,
    input wire logic sda_h_oe,
    input wire logic sda_d_o,
    input wire logic sda_d_oe,
    input wire logic sda_i
);
    logic scl_p_q, sda_p_q, first_q, busy_q, scl_s_q;
    logic [3:0] bit_q;
    logic [7:0] shift_q;
    logic [11:0] cnt_q;
    wire rise = scl_i & ~scl_p_q;
    wire start = scl_i & scl_p_q & sda_p_q & ~sda_i;
    wire stop = scl_i & scl_p_q & ~sda_p_q & sda_i;
    wire ninth = rise & (bit_q == 4'h8);
    wire own = shift_q[7:1] inside {7'h5a, 7'h5b, 7'h5c, 7'h5d};
    // bit position is decoded from the wire, so it never trusts the device's own count
    always_ff @(posedge clk_link) begin
        scl_p_q <= scl_i;
        sda_p_q <= sda_i;
        busy_q <= rst ? 1'b0 : (start | (busy_q & ~stop));
        first_q <= rst ? 1'b0 : (start | (first_q & ~ninth));
        bit_q <= (rst | start | ninth) ? 4'h0 : bit_q + {3'h0, rise};
        shift_q <= rise ? {shift_q[6:0], sda_i} : shift_q;
    end
    // saturating count of how long scl has kept its level
    always_ff @(posedge clk_sys) begin
        scl_s_q <= scl_i;
        cnt_q <= (rst | (scl_i != scl_s_q)) ? 12'h0 : cnt_q + {11'h0, cnt_q != 12'hfff};
    end
    chk_scl_pull_low: assert property (@(posedge clk_sys) disable iff (rst)
        scl_oe |-> !scl_o) else $error("host drives scl high");
    chk_dev_sda_od: assert property (@(posedge clk_link) disable iff (rst)
        sda_d_oe |-> !sda_d_o) else $error("device drives sda high");
    chk_host_sda_od: assert property (@(posedge clk_sys) disable iff (rst)
        sda_h_oe |-> !sda_h_o) else $error("host drives sda high");
    chk_dev_edge_low: assert property (@(posedge clk_link) disable iff (rst)
        $changed(sda_d_oe) |-> !scl_i && !scl_p_q) else $error("device sda moved in scl high");
    chk_scl_level_time: assert property (@(posedge clk_sys) disable iff (rst)
        (scl_i != scl_s_q) |-> cnt_q >= 12'h078) else $error("scl level too short");
    chk_dev_idle_quiet: assert property (@(posedge clk_link) disable iff (rst)
        !busy_q |-> !sda_d_oe) else $error("device pulls sda on idle bus");
    chk_addr_by_master: assert property (@(posedge clk_link) disable iff (rst)
        (rise && first_q && bit_q < 4'h8) |-> !sda_d_oe) else $error("device drove address bit");
    chk_ack_own_addr: assert property (@(posedge clk_link) disable iff (rst)
        (ninth && first_q && sda_d_oe) |-> own) else $error("device acked foreign address");
    chk_ack_held_high: assert property (@(posedge clk_link) disable iff (rst)
        (ninth && sda_d_oe) |-> (sda_d_oe && !sda_i)[*8]) else $error("ack not held");
    cover property (@(posedge clk_link) ninth && first_q && sda_d_oe);
    cover property (@(posedge clk_link) ninth && first_q && !sda_d_oe);
    cover property (@(posedge clk_link) stop && busy_q);
endmodule : tsi_link_properties

/* bench/tsi_dev_port_tb.sv */
`timescale 1ns/1ns
module tsi_dev_port_tb;
    import tsi_pkg::*;
    logic clk_sys = 1'b0;
    logic clk_link = 1'b0;
    logic rst = 1'b1;
    tsi_asel_t addr_sel = 2'h0;
    logic cmd_valid = 1'b0;
    tsi_op_t cmd_op = OP_START;
    logic [7:0] cmd_data = 8'h00;
    logic cmd_last = 1'b0;
    logic cmd_ready, rsp_valid, rsp_nack, reg_wr_en, reg_rd_en, link_busy;
    logic [7:0] rsp_data, reg_addr, reg_wdata, reg_rdata;
    logic [15:0] wr_q[$];
    logic [7:0] rd_q[$];
    int fail_count = 0;
    int tests_run = 0;
    always #10 clk_sys = ~clk_sys;
    always #15 clk_link = ~clk_link;
    // register storage stand-in: each address reads back a distinct pattern
    assign reg_rdata = reg_addr ^ 8'h3c;
    // sampled off the launching edge so the pulse and its fields are settled
    always @(negedge clk_sys) begin
        if (reg_wr_en === 1'b1) begin
            wr_q.push_back({reg_addr, reg_wdata});
        end
        if (reg_rd_en === 1'b1) begin
            rd_q.push_back(reg_addr);
        end
    end
    tsi_link_if link_if();
    tsi_dev_port tsi_dev_port_i (.clk_sys(clk_sys), .rst(rst), .clk_link(clk_link),
        .link(link_if.dev), .addr_sel(addr_sel), .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .link_busy(link_busy));
    tsi_host_master tsi_host_master_i (.clk_sys(clk_sys), .rst(rst), .link(link_if.host),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_data(cmd_data),
        .cmd_last(cmd_last), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_nack(rsp_nack));
    tsi_link_properties tsi_link_properties_i (.clk_sys(clk_sys), .rst(rst),
        .clk_link(clk_link), .scl_o(link_if.scl_o), .scl_oe(link_if.scl_oe),
        .scl_i(link_if.scl_i), .sda_h_o(link_if.sda_h_o), .sda_h_oe(link_if.sda_h_oe),
        .sda_d_o(link_if.sda_d_o), .sda_d_oe(link_if.sda_d_oe), .sda_i(link_if.sda_i));

    task automatic summarize();
        if (fail_count == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : summarize

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // one host command, held until taken, then waited out under a bound
    task automatic xfer(input tsi_op_t op, input logic [7:0] data, input logic last);
        int n;
        @(negedge clk_sys);
        cmd_op = op;
        cmd_data = data;
        cmd_last = last;
        cmd_valid = 1'b1;
        n = 0;
        // ready only moves on a posedge, so seen here it means the next posedge takes it
        while (cmd_ready !== 1'b1 && n < 100) begin
            @(negedge clk_sys);
            n++;
        end
        if (cmd_ready !== 1'b1) begin
            fail_count++;
            summarize();
        end
        @(negedge clk_sys);
        cmd_valid = 1'b0;
        do begin
            @(negedge clk_sys);
            n++;
        end while (cmd_ready !== 1'b1 && n < 6000);
        if (n >= 6000) begin
            fail_count++;
            summarize();
        end
    endtask : xfer

    task automatic wr(input logic [7:0] data, input logic nack);
        xfer(OP_WRITE, data, 1'b0);
        check({14'h0, rsp_valid, rsp_nack}, {14'h0, 1'b1, nack});
    endtask : wr

    task automatic rd(input logic last, input logic [8:0] exp);
        xfer(OP_READ, 8'h00, last);
        check({6'h0, rsp_valid, rsp_nack, rsp_data}, {6'h0, 1'b1, exp});
    endtask : rd

    // busy follows the bus a few cycles late, so allow a short bounded settle
    task automatic wait_busy(input logic exp);
        int n;
        for (n = 0; n < 50 && link_busy !== exp; n++) begin
            @(negedge clk_sys);
        end
        check({15'h0, link_busy}, {15'h0, exp});
    endtask : wait_busy

    task automatic sc_write();
        xfer(OP_START, 8'h00, 1'b0);
        wr(8'hb4, 1'b0);
        wait_busy(1'b1);
        wr(8'h7e, 1'b0);
        check(16'(wr_q.size()), 16'h0);
        wr(8'h11, 1'b0);
        wr(8'h22, 1'b0);
        xfer(OP_STOP, 8'h00, 1'b0);
        wait_busy(1'b0);
        check(16'(wr_q.size()), 16'h2);
        check(wr_q[0], 16'h7e11);
        check(wr_q[1], 16'h7f22);
        wr_q.delete();
    endtask : sc_write

    task automatic sc_read();
        xfer(OP_START, 8'h00, 1'b0);
        wr(8'hb4, 1'b0);
        wr(8'h7f, 1'b0);
        xfer(OP_START, 8'h00, 1'b0);
        wr(8'hb5, 1'b0);
        rd(1'b0, 9'h043);
        rd(1'b1, 9'h13c);
        xfer(OP_STOP, 8'h00, 1'b0);
        wait_busy(1'b0);
        check(16'(wr_q.size()), 16'h0);
        check(16'(rd_q.size()), 16'h3);
        check({8'h0, rd_q[0]}, 16'h007f);
        check({8'h0, rd_q[1]}, 16'h0000);
        check({8'h0, rd_q[2]}, 16'h0001);
        rd_q.delete();
    endtask : sc_read

    task automatic sc_ptr_only();
        xfer(OP_START, 8'h00, 1'b0);
        wr(8'hb4, 1'b0);
        wr(8'h30, 1'b0);
        xfer(OP_STOP, 8'h00, 1'b0);
        wait_busy(1'b0);
        check(16'(wr_q.size()), 16'h0);
        xfer(OP_START, 8'h00, 1'b0);
        wr(8'hb5, 1'b0);
        rd(1'b1, 9'h10c);
        xfer(OP_STOP, 8'h00, 1'b0);
        wait_busy(1'b0);
        check({8'h0, rd_q[0]}, 16'h0030);
        rd_q.delete();
    endtask : sc_ptr_only

    // same address byte against every strap: only the matching strap answers
    task automatic sc_strap();
        for (int s = 0; s < 4; s++) begin
            addr_sel = 2'(s);
            xfer(OP_START, 8'h00, 1'b0);
            wr(8'hb8, 1'(s != 2));
            wait_busy(1'(s == 2));
            xfer(OP_STOP, 8'h00, 1'b0);
            wait_busy(1'b0);
        end
        check(16'(wr_q.size()), 16'h0);
    endtask : sc_strap

    initial begin
        // four cycles still give the link side's two-flop reset sync edges in reset
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys);
        rst = 1'b0;
        repeat (10) @(negedge clk_sys);
        sc_write();
        sc_read();
        sc_ptr_only();
        sc_strap();
        summarize();
    end
endmodule : tsi_dev_port_tb
